// File: verilog/wdrs_pkg.sv
// constants for the watchdog and reset-cause block
package wdrs_pkg;
   // special function register addresses
   localparam logic [7:0] WDRS_ADDR_WATCHDOG_CONTROL = 8'h00E3;
   localparam logic [7:0] WDRS_ADDR_RESET_CAUSE = 8'h00EF;
   // watchdog control command bytes
   localparam logic [7:0] WDRS_CMD_RELOAD = 8'h00A5;
   localparam logic [7:0] WDRS_CMD_DISABLE_FIRST = 8'h00DE;
   localparam logic [7:0] WDRS_CMD_DISABLE_SECOND = 8'h00AD;
   localparam logic [7:0] WDRS_CMD_LOCKOUT = 8'h00FF;
   // watchdog control fields and reset value
   localparam logic [7:0] WDRS_CONTROL_RESET = 8'h0017;
   localparam int WDRS_CTL_CMD_BIT = 7;
   localparam int WDRS_CTL_ACTIVE_BIT = 4;
   localparam int WDRS_CTL_INTERVAL_LSB = 0;
   localparam int WDRS_INTERVAL_W = 3;
   localparam logic [2:0] WDRS_INTERVAL_RESET = 3'h7;
   // reset cause bit positions
   localparam int WDRS_RC_FLASH = 6;
   localparam int WDRS_RC_CMP = 5;
   localparam int WDRS_RC_SOFT = 4;
   localparam int WDRS_RC_WDOG = 3;
   localparam int WDRS_RC_MCLK = 2;
   localparam int WDRS_RC_POWER = 1;
   localparam int WDRS_RC_PIN = 0;
   localparam logic [7:0] WDRS_CAUSE_POWER_ON = 8'h0002;
   // timing: clock period and disable window
   localparam int WDRS_CLK_PERIOD_NS = 50;
   localparam int WDRS_DISABLE_WINDOW_CLOCKS = 4;
   localparam logic [2:0] WDRS_DISABLE_WINDOW = 3'(WDRS_DISABLE_WINDOW_CLOCKS);
   // watchdog counter: 21 bits, limit 4^(3+n) = 2^(6+2n) clocks
   localparam int WDRS_COUNTER_W = 21;
   localparam int WDRS_BASE_EXP = 6;
   // clocks a generated system reset is held
   localparam logic [7:0] WDRS_HOLD_CLOCKS = 8'h0008;
   // synchronised source indexes
   localparam int WDRS_SRC_PIN = 0;
   localparam int WDRS_SRC_CMP = 1;
   localparam int WDRS_SRC_MCLK = 2;
   localparam int WDRS_SRC_SUPPLY = 3;
   localparam int WDRS_SRC_N = 4;
endpackage : wdrs_pkg

// File: verilog/wdrs_counter.sv
// watchdog interval counter with overflow pulse
`timescale 1ns/1ns
module wdrs_counter #(
   parameter int COUNTER_W = wdrs_pkg::WDRS_COUNTER_W,
   parameter int BASE_EXP = wdrs_pkg::WDRS_BASE_EXP
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic run,
   input wire logic restart,
   input wire logic [wdrs_pkg::WDRS_INTERVAL_W-1:0] interval,
   output logic overflow
);
   import wdrs_pkg::*;

   typedef struct packed {
      logic [COUNTER_W-1:0] count;
      logic overflow;
   } wdrs_cnt_state_t;

   wdrs_cnt_state_t state_reg;
   wdrs_cnt_state_t state_next;
   logic [COUNTER_W-1:0] last_count;

   // elaboration check: the longest interval must fit the counter
   if (BASE_EXP < 1 || BASE_EXP + 14 > COUNTER_W) begin : g_narrow
      $error("wdrs_counter: counter too narrow for base exponent");
   end

   // last count before overflow: 2^(base+2n) - 1
   assign last_count = COUNTER_W'(({{(COUNTER_W){1'b0}}, 1'b1} << (BASE_EXP + 2 * interval)) - 1);

   // next-state logic
   always_comb begin
      state_next = state_reg;
      state_next.overflow = 1'b0;
      if (restart) begin
         state_next.count = '0;
      end else if (run) begin
         // R1 overflow forces reset
         if (state_reg.count >= last_count) begin
            state_next.count = '0;
            state_next.overflow = 1'b1;
         end else begin
            state_next.count = state_reg.count + 1'b1;
         end
      end
   end

   // state register
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= '0;
      end else begin
         state_reg <= state_next;
      end
   end

   assign overflow = state_reg.overflow;
endmodule : wdrs_counter

// File: verilog/wdrs_top.sv
// watchdog timer and reset-cause registers with reset hold sequencer
// Functional notes
// R1 - 21-bit clocked counter; overflow forces system reset
// R2 - after reset watchdog runs, interval reads 111
// R3 - write A5 enables and restarts counter
// R4 - DE then AD within 4 clocks disables
// R5 - FF sets lockout until next system reset
// R6 - FF neither enables nor restarts watchdog
// R7 - timeout is 4^(3+interval) clock periods
// R8 - software writes interval with bit 7 zero
// R9 - control read returns interval in bits 2:0
// R10 - control bit 4 reads watchdog active
// R11 - watchdog reset leaves external reset pin alone
// R12 - cause bit 6 flags flash fault reset
// R13 - bit 5 enables comparator, flags its reset
// R14 - writing bit 4 forces reset, then flags
// R15 - cause bit 3 flags watchdog overflow reset
// R16 - bit 2 enables missing clock, flags it
// R17 - bit 1 enables supply monitor, flags power
// R18 - software enables supply reset only once settled
// R19 - cause bit 0 flags external pin reset
// R20 - software writes cause register whole, no merge
// R21 - missing clock bit reads 0 otherwise
// R22 - other byte after DE cancels disable
// R23 - read-only cause bits ignore writes; bit7 zero
`timescale 1ns/1ns
module wdrs_top #(
   parameter int COUNTER_W = wdrs_pkg::WDRS_COUNTER_W,
   parameter int BASE_EXP = wdrs_pkg::WDRS_BASE_EXP,
   parameter logic [7:0] HOLD_CLOCKS = wdrs_pkg::WDRS_HOLD_CLOCKS
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   output logic [7:0] sfr_rdata,
   input wire logic reset_pin_n,
   input wire logic comparator_out_n,
   input wire logic missing_clock_timeout,
   input wire logic supply_low,
   input wire logic flash_fault,
   output logic system_reset_out,
   output logic watchdog_active
);
   import wdrs_pkg::*;

   // register state of the block apart from the watchdog counter, kept in one word
   typedef struct packed {
      // two flip-flops per pin-level source
      logic [WDRS_SRC_N-1:0] sync_first;
      logic [WDRS_SRC_N-1:0] sync_second;
      // watchdog control
      logic [WDRS_INTERVAL_W-1:0] interval;
      logic enabled;
      logic lockout;
      logic [2:0] disarm_cnt; // clocks left for the second disable byte
      // cause flags and write-only source enables
      logic [7:0] cause;
      logic en_cmp;
      logic en_mclk;
      logic en_supply;
      // hold sequencer and registered outputs
      logic [7:0] hold_cnt;
      logic system_reset;
      logic [7:0] rdata;
   } wdrs_state_t;

   // registered state and its next value
   wdrs_state_t state_reg;
   wdrs_state_t state_next;
   // source levels and watchdog counter controls
   logic [WDRS_SRC_N-1:0] src_raw;
   logic wd_overflow;
   logic wd_reset;
   logic wd_restart;
   logic in_hold;

   // elaboration checks on the parameters
   // a hold of zero clocks would never enter the hold, leaving only a one-clock request
   if (HOLD_CLOCKS == 8'h0000) begin : g_bad_hold
      $error("wdrs_top: reset hold must last at least one clock");
   end
   // the longest interval needs base plus fourteen counter bits
   if (BASE_EXP < 1 || BASE_EXP + 2 * (2 ** WDRS_INTERVAL_W - 1) > COUNTER_W) begin : g_narrow
      $error("wdrs_top: counter too narrow for the longest interval");
   end
   // the disable window must fit its three-bit down-counter
   if (WDRS_DISABLE_WINDOW_CLOCKS < 1 || WDRS_DISABLE_WINDOW_CLOCKS > 7) begin : g_bad_window
      $error("wdrs_top: disable window does not fit its counter");
   end

   // bus decode shared by read and write paths
   // a strobe only counts when the address matches exactly
   function automatic logic sfr_hit(input logic [7:0] addr, input logic [7:0] target,
                                    input logic strobe);
      sfr_hit = strobe && (addr == target);
   endfunction : sfr_hit

   // one-hot cause byte for a given bit position
   // keeps the cause byte one-hot by construction
   function automatic logic [7:0] cause_onehot(input int pos);
      cause_onehot = 8'(1 << pos);
   endfunction : cause_onehot

   // the sources come from other parts of the chip with no clock relation,
   // so they are only read after the two synchroniser stages
   // raw asynchronous sources, all turned active high
   assign src_raw[WDRS_SRC_PIN] = ~reset_pin_n;
   assign src_raw[WDRS_SRC_CMP] = ~comparator_out_n;
   assign src_raw[WDRS_SRC_MCLK] = missing_clock_timeout;
   assign src_raw[WDRS_SRC_SUPPLY] = supply_low;

   // a hold runs while its down-counter is not zero
   assign in_hold = (state_reg.hold_cnt != 8'h0000);

   // the counter is also held at zero for the whole hold
   // R2 watchdog defaults on every system reset
   assign wd_reset = reset || in_hold;

   // only the reload byte restarts; the lockout byte does not
   // R3 reload restarts counter
   assign wd_restart = sfr_hit(sfr_addr, WDRS_ADDR_WATCHDOG_CONTROL, sfr_wr) &&
                       (sfr_wdata == WDRS_CMD_RELOAD);

   // the counter lives in its own module so that its width and base exponent
   // can shrink for fast checks; the limit is 4^(3+n) = 2^(6+2n) clocks at
   // the default base, so interval 7 counts up to 2^20 - 1, inside 21 bits
   // it is held at zero for the whole hold, which is how every system reset
   // restarts the timeout from the beginning
   // R7 interval-scaled watchdog counter
   wdrs_counter #(
      .COUNTER_W(COUNTER_W),
      .BASE_EXP(BASE_EXP)
   ) u_counter (
      .core_clk(core_clk),
      .reset(wd_reset),
      .run(state_reg.enabled),
      .restart(wd_restart),
      .interval(state_reg.interval),
      .overflow(wd_overflow)
   );

   // how a clock of this block goes:
   // - a control write is decoded as a command byte first; a byte that is no
   //   command and has its top bit low loads the interval field, any other
   //   byte is dropped
   // - every control write clears the armed disable, so only a second byte
   //   landing inside the window right after the first can stop the watchdog
   // - the disable window counts down once per clock after the first byte,
   //   so the second byte is taken on any of the next four clocks
   // - the lockout bit only gates the second disable byte; it never touches
   //   the enable or the counter
   // - bus writes are dropped for the whole hold, reads are still served, so
   //   software can read the cause byte as soon as the hold ends
   // - a start of a hold overrides every write of the same clock, so a
   //   command that meets a reset is lost rather than half applied
   // next-state logic: syncs, control, causes, hold, read data
   always_comb begin
      logic ctl_wr;
      logic cause_wr;
      logic [7:0] new_cause;
      logic start;
      ctl_wr = 1'b0;
      cause_wr = 1'b0;
      new_cause = 8'h0000;
      start = 1'b0;
      state_next = state_reg;
      // two-stage synchronisers for pin-level sources
      state_next.sync_first = src_raw;
      state_next.sync_second = state_reg.sync_first;
      if (state_reg.disarm_cnt != 3'h0) begin
         state_next.disarm_cnt = state_reg.disarm_cnt - 3'h1;
      end
      if (!in_hold) begin
         ctl_wr = sfr_hit(sfr_addr, WDRS_ADDR_WATCHDOG_CONTROL, sfr_wr);
         cause_wr = sfr_hit(sfr_addr, WDRS_ADDR_RESET_CAUSE, sfr_wr);
      end
      // watchdog control byte commands
      if (ctl_wr) begin
         // R22 any other byte drops the armed disable
         state_next.disarm_cnt = 3'h0;
         case (sfr_wdata)
            WDRS_CMD_RELOAD: begin
               // R3 enable and reload
               state_next.enabled = 1'b1;
            end
            WDRS_CMD_DISABLE_FIRST: begin
               // R4 arm disable window
               state_next.disarm_cnt = WDRS_DISABLE_WINDOW;
            end
            WDRS_CMD_DISABLE_SECOND: begin
               // R5 lockout blocks disable
               if (state_reg.disarm_cnt != 3'h0 && !state_reg.lockout) begin
                  state_next.enabled = 1'b0;
               end
            end
            WDRS_CMD_LOCKOUT: begin
               // R6 lockout only
               state_next.lockout = 1'b1;
            end
            default: begin
               // R8 interval written with bit 7 low
               if (!sfr_wdata[WDRS_CTL_CMD_BIT]) begin
                  state_next.interval = sfr_wdata[WDRS_CTL_INTERVAL_LSB +: WDRS_INTERVAL_W];
               end
            end
         endcase
      end
      // R23 only enable bits are writable
      if (cause_wr) begin
         state_next.en_cmp = sfr_wdata[WDRS_RC_CMP];
         state_next.en_mclk = sfr_wdata[WDRS_RC_MCLK];
         state_next.en_supply = sfr_wdata[WDRS_RC_POWER];
      end
      // one cause wins when several trip together: supply, pin, missing
      // clock, comparator, flash, watchdog, then the software request;
      // the cause byte is loaded whole, so flags of an earlier reset clear
      // a source that trips during the hold is not recorded, except the pin,
      // which reloads the hold count for as long as it stays asserted
      // the software request is taken from the write itself, not from a
      // stored bit, so it cannot fire a second time
      // reset sources in priority order, caught only outside a hold
      if (!in_hold) begin
         start = 1'b1;
         if (state_reg.en_supply && state_reg.sync_second[WDRS_SRC_SUPPLY]) begin
            // R17 supply monitor reset
            new_cause = cause_onehot(WDRS_RC_POWER);
         end else if (state_reg.sync_second[WDRS_SRC_PIN]) begin
            // R19 pin reset
            new_cause = cause_onehot(WDRS_RC_PIN);
         end else if (state_reg.en_mclk && state_reg.sync_second[WDRS_SRC_MCLK]) begin
            // R16 missing clock reset
            new_cause = cause_onehot(WDRS_RC_MCLK);
         end else if (state_reg.en_cmp && state_reg.sync_second[WDRS_SRC_CMP]) begin
            // R13 comparator reset
            new_cause = cause_onehot(WDRS_RC_CMP);
         end else if (flash_fault) begin
            // R12 flash fault reset
            new_cause = cause_onehot(WDRS_RC_FLASH);
         end else if (wd_overflow) begin
            // R15 watchdog overflow reset
            new_cause = cause_onehot(WDRS_RC_WDOG);
         end else if (cause_wr && sfr_wdata[WDRS_RC_SOFT]) begin
            // R14 software forced reset
            new_cause = cause_onehot(WDRS_RC_SOFT);
         end else begin
            start = 1'b0;
         end
      end else if (state_reg.sync_second[WDRS_SRC_PIN]) begin
         // pin held low keeps the system in reset
         state_next.hold_cnt = HOLD_CLOCKS;
      end else begin
         state_next.hold_cnt = state_reg.hold_cnt - 8'h0001;
      end
      if (start) begin
         // R21 only the true cause flag is set
         state_next.cause = new_cause;
         state_next.hold_cnt = HOLD_CLOCKS;
         // R2 system reset restores watchdog defaults
         state_next.enabled = 1'b1;
         state_next.lockout = 1'b0;
         state_next.interval = WDRS_INTERVAL_RESET;
         state_next.disarm_cnt = 3'h0;
         state_next.en_cmp = 1'b0;
         state_next.en_mclk = 1'b0;
         state_next.en_supply = 1'b0;
      end
      // R11 only the internal reset request is driven, never the pin
      state_next.system_reset = start || (in_hold && state_next.hold_cnt != 8'h0000);
      // read data is registered and stays until the next read strobe;
      // an unmapped read returns zero, a write leaves it alone
      // registered read data
      if (sfr_hit(sfr_addr, WDRS_ADDR_WATCHDOG_CONTROL, sfr_rd)) begin
         state_next.rdata = 8'h0000;
         // R9 interval readback
         state_next.rdata[WDRS_CTL_INTERVAL_LSB +: WDRS_INTERVAL_W] = state_reg.interval;
         // R10 active status bit
         state_next.rdata[WDRS_CTL_ACTIVE_BIT] = state_reg.enabled;
      end else if (sfr_hit(sfr_addr, WDRS_ADDR_RESET_CAUSE, sfr_rd)) begin
         // R23 top bit reads zero
         state_next.rdata = {1'b0, state_reg.cause[6:0]};
      end else if (sfr_rd) begin
         state_next.rdata = 8'h0000;
      end
   end

   // the reset input is the power-on reset: it does not pass through the
   // hold sequencer and leaves only the power flag set in the cause byte
   // state register; power-on clears all but the interval, the enable and the power flag
   always_ff @(posedge core_clk) begin
      if (reset) begin
         state_reg <= '0;
         state_reg.interval <= WDRS_INTERVAL_RESET;
         state_reg.enabled <= 1'b1;
         state_reg.cause <= WDRS_CAUSE_POWER_ON;
      end else begin
         state_reg <= state_next;
      end
   end

   // outputs straight from the state register
   // every output is a flip-flop, never a gate behind one
   assign sfr_rdata = state_reg.rdata;
   assign system_reset_out = state_reg.system_reset;
   assign watchdog_active = state_reg.enabled;
endmodule : wdrs_top

// File: bench/wdrs_top_props.sv
// assertion checker for the watchdog and reset-cause block
`timescale 1ns/1ns
module wdrs_top_props #(
   parameter logic [7:0] HOLD_CLOCKS = 8'h08
) (
   input wire logic core_clk,
   input wire logic reset,
   input wire logic [7:0] sfr_addr,
   input wire logic sfr_wr,
   input wire logic sfr_rd,
   input wire logic [7:0] sfr_wdata,
   input wire logic [7:0] sfr_rdata,
   input wire logic reset_pin_n,
   input wire logic comparator_out_n,
   input wire logic missing_clock_timeout,
   input wire logic supply_low,
   input wire logic flash_fault,
   input wire logic system_reset_out,
   input wire logic watchdog_active
);
   import wdrs_pkg::*;
   logic [7:0] hold_cnt_reg;
   logic [7:0] hold_cnt_next;
   logic ctl_wr;
   default clocking @(posedge core_clk);
   endclocking
   default disable iff (reset);
   // length of the current reset hold
   always_comb begin
      hold_cnt_next = system_reset_out ? hold_cnt_reg + 8'h01 : 8'h00;
   end
   always_ff @(posedge core_clk) begin
      hold_cnt_reg <= reset ? 8'h00 : hold_cnt_next;
   end
   assign ctl_wr = sfr_wr && (sfr_addr == WDRS_ADDR_WATCHDOG_CONTROL);
   hold_length_a: assert property ($fell(system_reset_out) |-> hold_cnt_reg >= HOLD_CLOCKS)
      else $error("system reset hold too short");
   soft_force_a: assert property (sfr_wr && sfr_addr == WDRS_ADDR_RESET_CAUSE
      && sfr_wdata[WDRS_RC_SOFT] && !system_reset_out |=> system_reset_out)
      else $error("software reset not forced");
   reload_enable_a: assert property (ctl_wr && sfr_wdata == WDRS_CMD_RELOAD
      && !system_reset_out |=> watchdog_active) else $error("reload did not enable");
   lockout_quiet_a: assert property (ctl_wr && sfr_wdata == WDRS_CMD_LOCKOUT
      && !watchdog_active && !system_reset_out |=> !watchdog_active || system_reset_out)
      else $error("lockout byte enabled the watchdog");
   hold_reenable_a: assert property (system_reset_out |=> watchdog_active)
      else $error("watchdog not enabled by system reset");
   status_bit_a: assert property (sfr_rd && sfr_addr == WDRS_ADDR_WATCHDOG_CONTROL
      |=> sfr_rdata[WDRS_CTL_ACTIVE_BIT] == $past(watchdog_active))
      else $error("status bit differs from active state");
   top_bit_a: assert property (sfr_rd && sfr_addr == WDRS_ADDR_RESET_CAUSE
      |=> !sfr_rdata[7]) else $error("unused cause bit reads one");
   only_second_a: assert property (watchdog_active
      && !(ctl_wr && sfr_wdata == WDRS_CMD_DISABLE_SECOND) |=> watchdog_active)
      else $error("watchdog stopped without second byte");
endmodule : wdrs_top_props
bind wdrs_top wdrs_top_props #(.HOLD_CLOCKS(HOLD_CLOCKS)) wdrs_top_props_inst (
   .core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
   .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
   .reset_pin_n(reset_pin_n), .comparator_out_n(comparator_out_n),
   .missing_clock_timeout(missing_clock_timeout), .supply_low(supply_low),
   .flash_fault(flash_fault), .system_reset_out(system_reset_out),
   .watchdog_active(watchdog_active)
);

// File: bench/wdrs_top_tb.sv
// self-checking bench for the watchdog and reset-cause block
`timescale 1ns/1ns
module wdrs_top_tb;
   import wdrs_pkg::*;
   logic core_clk = 1'b0;
   logic reset = 1'b1;
   logic [7:0] sfr_addr = 8'h00;
   logic sfr_wr = 1'b0;
   logic sfr_rd = 1'b0;
   logic [7:0] sfr_wdata = 8'h00;
   logic [7:0] sfr_rdata;
   logic [3:0] src = 4'h0; // pin, comparator, missing clock, supply trips
   logic flash_fault = 1'b0;
   logic system_reset_out;
   logic watchdog_active;
   int fail_count = 0;
   int total_checks = 0;
   int cnt;
   // 20 MHz clock
   always #(WDRS_CLK_PERIOD_NS / 2) core_clk = ~core_clk;
   // shortened timeout base so a timeout takes a few clocks
   localparam int TB_BASE_EXP = 1;
   wdrs_top #(.BASE_EXP(TB_BASE_EXP)) wdrs_top_inst (
      .core_clk(core_clk), .reset(reset), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr),
      .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
      .reset_pin_n(~src[0]), .comparator_out_n(~src[1]), .missing_clock_timeout(src[2]),
      .supply_low(src[3]), .flash_fault(flash_fault), .system_reset_out(system_reset_out),
      .watchdog_active(watchdog_active)
   );
   // compare and count
   task automatic check(input logic [7:0] seen, input logic [7:0] exp, input string what);
      total_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask : give_verdict
   // register bus cycles; a write leaves its strobe up for back-to-back use
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      sfr_addr <= a;
      sfr_wdata <= d;
      sfr_rd <= 1'b0;
      sfr_wr <= 1'b1;
      @(posedge core_clk);
   endtask : wr
   task automatic idle(input int n);
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b0;
      repeat (n) @(posedge core_clk);
   endtask : idle
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      sfr_addr <= a;
      sfr_wr <= 1'b0;
      sfr_rd <= 1'b1;
      @(posedge core_clk);
      sfr_rd <= 1'b0;
      @(posedge core_clk);
      #1 check(sfr_rdata, exp, "sfr_rdata");
      @(posedge core_clk);
   endtask : rd
   task automatic act(input logic a, input logic r);
      #1 check({7'h00, watchdog_active}, {7'h00, a}, "watchdog_active");
      check({7'h00, system_reset_out}, {7'h00, r}, "system_reset_out");
      @(posedge core_clk);
   endtask : act
   // bounded wait for the reset request level, cycles counted in cnt
   task automatic await(input logic val, input int limit);
      #1 cnt = 0;
      while (system_reset_out !== val) begin
         @(posedge core_clk);
         #1 cnt++;
         if (cnt > limit) begin
            check({7'h00, system_reset_out}, {7'h00, val}, "reset wait");
            give_verdict();
         end
      end
      @(posedge core_clk);
   endtask : await
   task automatic t_reset();
      rd(WDRS_ADDR_WATCHDOG_CONTROL, 8'h17);
      rd(WDRS_ADDR_RESET_CAUSE, 8'h02);
      rd(8'h80, 8'h00);
      act(1'b1, 1'b0);
      $display("reset values done");
   endtask : t_reset
   task automatic t_disable();
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b0, 1'b0);
      rd(WDRS_ADDR_WATCHDOG_CONTROL, 8'h07);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'h00);
      rd(WDRS_ADDR_WATCHDOG_CONTROL, 8'h00);
      idle(20);
      act(1'b0, 1'b0);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hA5);
      idle(1);
      await(1'b1, 40);
      // wait starts a clock after the reload, request comes limit + 1 after it
      check(8'(cnt), 8'(1 << TB_BASE_EXP), "timeout cycles");
      await(1'b0, 40);
      rd(WDRS_ADDR_RESET_CAUSE, 8'h08);
      rd(WDRS_ADDR_WATCHDOG_CONTROL, 8'h17);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hA5);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'h01);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hA5);
      idle(1);
      await(1'b1, 40);
      check(8'(cnt), 8'(1 << (TB_BASE_EXP + 2)), "timeout cycles");
      await(1'b0, 40);
      $display("disable and timeout done");
   endtask : t_disable
   task automatic t_window();
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      idle(4);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b1, 1'b0);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hA5);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b1, 1'b0);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      idle(3);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b0, 1'b0);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hA5);
      idle(1);
      act(1'b1, 1'b0);
      $display("disable window done");
   endtask : t_window
   task automatic t_lock();
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hFF);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b1, 1'b0);
      wr(WDRS_ADDR_RESET_CAUSE, 8'h10);
      idle(1);
      await(1'b1, 4);
      await(1'b0, 20);
      rd(WDRS_ADDR_RESET_CAUSE, 8'h10);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hDE);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hAD);
      idle(1);
      act(1'b0, 1'b0);
      wr(WDRS_ADDR_WATCHDOG_CONTROL, 8'hFF);
      idle(1);
      act(1'b0, 1'b0);
      $display("lockout done");
   endtask : t_lock
   task automatic t_sources();
      logic [7:0] en [5] = '{8'h00, 8'h20, 8'h04, 8'h02, 8'h00};
      logic [7:0] cause [5] = '{8'h01, 8'h20, 8'h04, 8'h02, 8'h40};
      wr(WDRS_ADDR_RESET_CAUSE, 8'hC9);
      idle(1);
      src[1] <= 1'b1;
      repeat (8) @(posedge core_clk);
      src <= 4'h0;
      act(1'b0, 1'b0);
      rd(WDRS_ADDR_RESET_CAUSE, 8'h10);
      for (int k = 0; k < 5; k++) begin
         wr(WDRS_ADDR_RESET_CAUSE, en[k]);
         idle(1);
         if (k < 4) src[k] <= 1'b1;
         else flash_fault <= 1'b1;
         repeat (3) @(posedge core_clk);
         src <= 4'h0;
         flash_fault <= 1'b0;
         await(1'b1, 10);
         await(1'b0, 30);
         rd(WDRS_ADDR_RESET_CAUSE, cause[k]);
      end
      $display("reset sources done");
   endtask : t_sources
   // reset, then the scenarios in turn
   initial begin
      repeat (12) @(posedge core_clk);
      reset <= 1'b0;
      @(posedge core_clk);
      t_reset();
      t_disable();
      t_window();
      t_lock();
      t_sources();
      give_verdict();
   end
endmodule : wdrs_top_tb
